// ---- ima_tx_cfg_pkg.sv ----
// Package of constants for the transmit link and group configuration registers
package ima_tx_cfg_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_LINKS = 8;
  localparam int NUM_GROUPS = 4;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Register byte addresses (direct access)
  // ----------------------------------------------------------------
  localparam logic [8:0] ADDR_FRAME_BASE = 9'h0C0;
  localparam logic [8:0] ADDR_OFFSET_BASE = 9'h0C4;
  localparam logic [8:0] ADDR_LINK_CTL_BASE = 9'h0CC;
  localparam logic [8:0] ADDR_GROUP_CTL_BASE = 9'h0D4;
  localparam logic [8:0] ADDR_MODE_STATUS = 9'h0EF;
  localparam logic [8:0] ADDR_INTEG_BASE = 9'h200;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FRAME_CFG_RST = 8'h58;
  localparam logic [7:0] LINK_CTL_RST = 8'h04;
  localparam logic [7:0] GROUP_CTL_RST = 8'h29;
  localparam logic [3:0] INTEG_CODE_RST = 4'h5;
  localparam logic [7:0] MODE_STATUS_RST = 8'hFF;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Link control field positions
  // ----------------------------------------------------------------
  localparam int LCTL_USER_BIT = 6;
  localparam int LCTL_NOCOSET_BIT = 5;
  localparam int LCTL_SCRAMBLE_BIT = 4;
  localparam int LCTL_UNI_BIT = 2;
  localparam int LCTL_GROUP_LSB = 0;
  localparam int GROUP_W = 2;

  // ----------------------------------------------------------------
  // Group control and frame field positions
  // ----------------------------------------------------------------
  localparam int GCTL_STUFF_BIT = 7;
  localparam int GCTL_OVER_LSB = 3;
  localparam int GCTL_OVER_W = 4;
  localparam int GCTL_UNDER_LSB = 0;
  localparam int GCTL_UNDER_W = 3;
  localparam int FRAME_M_LSB = 5;
  localparam int FRAME_M_W = 2;
  localparam int INTEG_CODE_W = 4;

  // ----------------------------------------------------------------
  // Frame length codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FRAME_32 = 2'h0,
    FRAME_64 = 2'h1,
    FRAME_128 = 2'h2,
    FRAME_256 = 2'h3
  } frame_len_e;

  // ----------------------------------------------------------------
  // Integration period: 2^(code + bias) cycles
  // ----------------------------------------------------------------
  localparam int INTEG_EXP_BIAS = 7;
  localparam logic [3:0] INTEG_CODE_RSVD = 4'hF;
  localparam logic [3:0] INTEG_CODE_MAX = 4'hE;
  localparam int INTEG_CNT_W = 22;

endpackage

// ---- link_tx_decode.sv ----
// Per-link decode of offset mask and transmit mode controls
`timescale 1ns/1ps
`default_nettype none
module link_tx_decode
  import ima_tx_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register contents
  input wire logic [7:0] offset,
  input wire logic [7:0] ctrl,
  input wire logic [1:0] frame_code,
  input wire logic phy_enable,
  // Decoded controls
  output logic [7:0] offset_used,
  output logic send_user,
  output logic coset_add,
  output logic scramble,
  output logic uni_mode,
  output logic [1:0] group
);

  // ----------------------------------------------------------------
  // Offset masking
  // ----------------------------------------------------------------
  // Keep only the bits that index a frame of the given length
  function automatic logic [7:0] mask_offset(input logic [7:0] val, input logic [1:0] code);
    logic [7:0] m;
    m = 8'hFF;
    unique case (frame_len_e'(code))
      FRAME_32: m = 8'h1F;
      FRAME_64: m = 8'h3F;
      FRAME_128: m = 8'h7F;
      FRAME_256: m = 8'hFF;
    endcase
    return val & m;
  endfunction

  logic [7:0] offset_nxt; // Masked offset
  logic send_nxt; // User cell gate
  logic uni;

  // Next values of decoded outputs
  always_comb begin
    uni = ctrl[LCTL_UNI_BIT];
    offset_nxt = uni ? READ_ZERO : mask_offset(offset, frame_code);
    // UNI traffic is gated by the cell-bus enable, not the register bit
    send_nxt = uni ? phy_enable : ctrl[LCTL_USER_BIT];
  end

  // Register outputs
  always_ff @(posedge clock) begin
    if (srst) begin
      offset_used <= READ_ZERO;
      send_user <= 1'b0;
      coset_add <= 1'b1;
      scramble <= 1'b0;
      uni_mode <= 1'b1;
      group <= '0;
    end else begin
      offset_used <= offset_nxt;
      send_user <= send_nxt;
      coset_add <= ~ctrl[LCTL_NOCOSET_BIT];
      scramble <= ctrl[LCTL_SCRAMBLE_BIT];
      uni_mode <= uni;
      group <= ctrl[LCTL_GROUP_LSB +: GROUP_W];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  offset_mask_a: assert property (@(posedge clock) disable iff (srst)
    (frame_code == FRAME_32) && !uni |=> offset_used[7:5] == 3'h0 && offset_used[4:0] == $past(offset[4:0]))
    else $error("offset not masked to five bits");

endmodule
`default_nettype wire

// ---- integration_timer.sv ----
// Per-group integration period tick generator
`timescale 1ns/1ps
`default_nettype none
module integration_timer
  import ima_tx_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Period code
  input wire logic [3:0] code,
  // One-cycle tick at end of each period
  output logic tick
);

  logic [INTEG_CNT_W-1:0] cnt_r, cnt_nxt; // Cycle count
  logic tick_r, tick_nxt;
  logic [INTEG_CNT_W-1:0] last; // Final count of period
  logic [3:0] eff; // Clamped code

  // Next count; period is 2^(code+bias) cycles
  always_comb begin
    // Reserved code is not used as given; clamp it to the longest, INTEG_CODE_MAX
    eff = (code == INTEG_CODE_RSVD) ? INTEG_CODE_MAX : code;
    // Exponent summed at five bits; four would wrap for codes of 9 and up
    last = INTEG_CNT_W'((23'h1 << (5'(eff) + 5'(INTEG_EXP_BIAS))) - 23'h1);
    tick_nxt = (cnt_r >= last);
    cnt_nxt = tick_nxt ? '0 : cnt_r + 1'b1;
  end

  // Register count and tick
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // A code change can leave the count past the new end; it still ticks
  period_tick_a: assert property (@(posedge clock) disable iff (srst)
    tick |-> $past(cnt_r) >= $past(last))
    else $error("integration tick at wrong count");

endmodule
`default_nettype wire

// ---- ima_tx_link_group_config.sv ----
// Transmit link and group configuration register bank
//
// Overview of operation
// - Link offset masked to frame length bits
// - Offset used in IMA; resets to link index
// - Group code selects power-of-two integration period
// - Integration upper nibble reads zero; reset 0101
// - IMA: user bit enables user cells
// - UNI: cell-bus PHY enable gates user cells
// - Bit five clear adds coset to HEC
// - Bit four set scrambles link cells
// - Bit two selects UNI; resets UNI
// - Bits one-zero give link's IMA group
// - Group bit seven: stuff lead one/four frames
// - Group bits six-three: overflow limit, reset five
// - Group bits two-zero: underflow limit; reset one
// - Two-bit group field gives frame length
// - Status byte: ones for links not IMA
`timescale 1ns/1ps
`default_nettype none
module ima_tx_link_group_config
  import ima_tx_cfg_pkg::*;
#(
  parameter int LINKS = NUM_LINKS,
  parameter int GROUPS = NUM_GROUPS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Processor register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  // Cell-bus input side enables, UNI mode
  input wire logic [LINKS-1:0] phy_user_enable,
  // Datapath reports a link has left IMA operation
  input wire logic [LINKS-1:0] link_drain_done,
  // Per-link controls
  output logic [LINKS-1:0][7:0] link_offset,
  output logic [LINKS-1:0] link_send_user,
  output logic [LINKS-1:0] link_coset_add,
  output logic [LINKS-1:0] link_scramble,
  output logic [LINKS-1:0] link_uni_mode,
  output logic [LINKS-1:0][1:0] link_group,
  // Per-group controls
  output logic [GROUPS-1:0] group_integ_tick,
  output logic [GROUPS-1:0] group_stuff_lead_four,
  output logic [GROUPS-1:0][3:0] group_over_limit,
  output logic [GROUPS-1:0][2:0] group_under_limit,
  output logic [GROUPS-1:0][1:0] group_frame_len
);

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  // True when a lies in the block of n bytes starting at base
  function automatic logic in_block(input logic [8:0] a, input logic [8:0] base, input int n);
    return (a >= base) && (a < base + 9'(n));
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [LINKS-1:0][7:0] offs_r, offs_nxt; // Control-cell offsets
  logic [LINKS-1:0][7:0] lctl_r, lctl_nxt; // Link control
  logic [GROUPS-1:0][7:0] gctl_r, gctl_nxt; // Group control
  logic [GROUPS-1:0][7:0] gfrm_r, gfrm_nxt; // Group frame config
  logic [GROUPS-1:0][3:0] gint_r, gint_nxt; // Integration codes
  logic [LINKS-1:0] ima_act_r, ima_act_nxt; // Link running in IMA
  logic [7:0] rdata_r, rdata_nxt; // Read data
  logic [8:0] idx; // Offset into a block
  logic [7:0] status; // Mode status view

  // Next register values from writes
  always_comb begin
    offs_nxt = offs_r;
    lctl_nxt = lctl_r;
    gctl_nxt = gctl_r;
    gfrm_nxt = gfrm_r;
    gint_nxt = gint_r;
    idx = '0;
    if (wr_en) begin
      if (in_block(addr, ADDR_OFFSET_BASE, LINKS)) begin
        idx = addr - ADDR_OFFSET_BASE;
        offs_nxt[idx] = wdata;
      end else if (in_block(addr, ADDR_LINK_CTL_BASE, LINKS)) begin
        idx = addr - ADDR_LINK_CTL_BASE;
        lctl_nxt[idx] = wdata;
      end else if (in_block(addr, ADDR_GROUP_CTL_BASE, GROUPS)) begin
        idx = addr - ADDR_GROUP_CTL_BASE;
        gctl_nxt[idx] = wdata;
      end else if (in_block(addr, ADDR_FRAME_BASE, GROUPS)) begin
        idx = addr - ADDR_FRAME_BASE;
        gfrm_nxt[idx] = wdata;
      end else if (in_block(addr, ADDR_INTEG_BASE, GROUPS)) begin
        idx = addr - ADDR_INTEG_BASE;
        gint_nxt[idx] = wdata[INTEG_CODE_W-1:0];
      end
    end
  end

  // Register bank storage
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < LINKS; i++) begin
        offs_r[i] <= 8'(i);
        lctl_r[i] <= LINK_CTL_RST;
      end
      for (int g = 0; g < GROUPS; g++) begin
        gctl_r[g] <= GROUP_CTL_RST;
        gfrm_r[g] <= FRAME_CFG_RST;
        gint_r[g] <= INTEG_CODE_RST;
      end
    end else begin
      offs_r <= offs_nxt;
      lctl_r <= lctl_nxt;
      gctl_r <= gctl_nxt;
      gfrm_r <= gfrm_nxt;
      gint_r <= gint_nxt;
    end
  end

  // ----------------------------------------------------------------
  // IMA mode status tracking
  // ----------------------------------------------------------------
  // Entering IMA is immediate; leaving waits for the datapath, so the
  // group number must stay put until the status bit returns to one
  always_comb begin
    for (int i = 0; i < LINKS; i++) begin
      if (!lctl_r[i][LCTL_UNI_BIT]) begin
        ima_act_nxt[i] = 1'b1;
      end else if (link_drain_done[i]) begin
        ima_act_nxt[i] = 1'b0;
      end else begin
        ima_act_nxt[i] = ima_act_r[i];
      end
    end
    status = ~8'(ima_act_r);
  end

  // Mode tracking register
  always_ff @(posedge clock) begin
    if (srst) begin
      ima_act_r <= '0;
    end else begin
      ima_act_r <= ima_act_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data is held between reads; unmapped addresses read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_en) begin
      rdata_nxt = READ_ZERO;
      if (in_block(addr, ADDR_OFFSET_BASE, LINKS)) begin
        rdata_nxt = offs_r[3'(addr - ADDR_OFFSET_BASE)];
      end else if (in_block(addr, ADDR_LINK_CTL_BASE, LINKS)) begin
        rdata_nxt = lctl_r[3'(addr - ADDR_LINK_CTL_BASE)];
      end else if (in_block(addr, ADDR_GROUP_CTL_BASE, GROUPS)) begin
        rdata_nxt = gctl_r[2'(addr - ADDR_GROUP_CTL_BASE)];
      end else if (in_block(addr, ADDR_FRAME_BASE, GROUPS)) begin
        rdata_nxt = gfrm_r[2'(addr - ADDR_FRAME_BASE)];
      end else if (in_block(addr, ADDR_INTEG_BASE, GROUPS)) begin
        rdata_nxt = {4'h0, gint_r[2'(addr - ADDR_INTEG_BASE)]};
      end else if (addr == ADDR_MODE_STATUS) begin
        rdata_nxt = status;
      end
    end
  end

  // Read data register
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_r <= READ_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  // ----------------------------------------------------------------
  // Per-link decode
  // ----------------------------------------------------------------
  for (genvar l = 0; l < LINKS; l++) begin : g_link
    link_tx_decode u_dec (
      .clock(clock),
      .srst(srst),
      .offset(offs_r[l]),
      .ctrl(lctl_r[l]),
      .frame_code(gfrm_r[lctl_r[l][LCTL_GROUP_LSB +: GROUP_W]][FRAME_M_LSB +: FRAME_M_W]),
      .phy_enable(phy_user_enable[l]),
      .offset_used(link_offset[l]),
      .send_user(link_send_user[l]),
      .coset_add(link_coset_add[l]),
      .scramble(link_scramble[l]),
      .uni_mode(link_uni_mode[l]),
      .group(link_group[l])
    );
  end

  // ----------------------------------------------------------------
  // Per-group outputs
  // ----------------------------------------------------------------
  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    integration_timer u_tmr (
      .clock(clock),
      .srst(srst),
      .code(gint_r[g]),
      .tick(group_integ_tick[g])
    );
    // Outputs straight from the register flip-flops
    assign group_stuff_lead_four[g] = gctl_r[g][GCTL_STUFF_BIT];
    assign group_over_limit[g] = gctl_r[g][GCTL_OVER_LSB +: GCTL_OVER_W];
    assign group_under_limit[g] = gctl_r[g][GCTL_UNDER_LSB +: GCTL_UNDER_W];
    assign group_frame_len[g] = gfrm_r[g][FRAME_M_LSB +: FRAME_M_W];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // Reset checks start while srst is high, so they override the default disable
  offset_reset_a: assert property (@(posedge clock) disable iff (1'b0)
    srst |=> offs_r[3] == 8'h03 && offs_r[7] == 8'h07)
    else $error("offset reset is not the link index");
  integ_read_a: assert property (rd_en && in_block(addr, ADDR_INTEG_BASE, GROUPS) |=> rdata[7:4] == 4'h0)
    else $error("integration upper nibble not zero");
  user_gate_a: assert property (wr_en && addr == ADDR_LINK_CTL_BASE && wdata[6] && !wdata[2] |=> ##1 link_send_user[0])
    else $error("user cells not enabled in IMA mode");
  uni_gate_a: assert property (lctl_r[1][2] && !phy_user_enable[1] |=> !link_send_user[1])
    else $error("UNI link sends user cells without enable");
  coset_ctl_a: assert property (wr_en && addr == ADDR_LINK_CTL_BASE + 9'h1 |=> ##1 link_coset_add[1] == !$past(wdata[5], 2))
    else $error("coset control wrong");
  scramble_ctl_a: assert property (wr_en && addr == ADDR_LINK_CTL_BASE + 9'h2 |=> ##1 link_scramble[2] == $past(wdata[4], 2))
    else $error("scramble control wrong");
  mode_reset_a: assert property (@(posedge clock) disable iff (1'b0)
    srst ##1 !srst |=> link_uni_mode == '1)
    else $error("links not in UNI after reset");
  group_num_a: assert property (wr_en && addr == ADDR_LINK_CTL_BASE + 9'h3 |=> ##1 link_group[3] == $past(wdata[1:0], 2))
    else $error("group number not applied");
  stuff_lead_a: assert property (wr_en && addr == ADDR_GROUP_CTL_BASE |=> group_stuff_lead_four[0] == $past(wdata[7]))
    else $error("stuff lead not applied");
  over_limit_a: assert property (@(posedge clock) disable iff (1'b0)
    srst |=> group_over_limit[2] == 4'h5)
    else $error("overflow limit reset wrong");
  group_reset_a: assert property (@(posedge clock) disable iff (1'b0)
    srst |=> gctl_r[1] == 8'h29 && group_under_limit[1] == 3'h1)
    else $error("group control reset wrong");
  status_read_a: assert property (rd_en && addr == ADDR_MODE_STATUS |=> rdata == ~$past(8'(ima_act_r)))
    else $error("mode status read wrong");
  status_reset_a: assert property (@(posedge clock) disable iff (1'b0)
    srst |=> status == 8'hFF)
    else $error("mode status not all ones after reset");

endmodule
`default_nettype wire

// ---- ima_tx_link_group_config_tb_top.sv ----
// Self-checking testbench for the transmit link and group configuration bank
`timescale 1ns/1ps
`default_nettype none
module ima_tx_link_group_config_tb_top
  import ima_tx_cfg_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [7:0] phy_user_enable = 8'h00;
  logic [7:0] link_drain_done = 8'h00;
  logic [7:0][7:0] link_offset;
  logic [7:0] link_send_user, link_coset_add, link_scramble, link_uni_mode;
  logic [7:0][1:0] link_group;
  logic [3:0] group_integ_tick, group_stuff_lead_four;
  logic [3:0][3:0] group_over_limit;
  logic [3:0][2:0] group_under_limit;
  logic [3:0][1:0] group_frame_len;
  int n_fail = 0; // Mismatch count
  int n_tests = 0; // Comparison count
  logic [7:0] rd_val; // Last value read
  int gap; // Cycles between ticks

  // Clock of 10 ns period
  always #5 clock = ~clock;

  // ----------------------------------------------------------------
  // Device under test
  // ----------------------------------------------------------------
  ima_tx_link_group_config #(.LINKS(8), .GROUPS(4)) ima_tx_link_group_config_inst (
    .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .phy_user_enable(phy_user_enable), .link_drain_done(link_drain_done),
    .link_offset(link_offset), .link_send_user(link_send_user), .link_coset_add(link_coset_add),
    .link_scramble(link_scramble), .link_uni_mode(link_uni_mode), .link_group(link_group),
    .group_integ_tick(group_integ_tick), .group_stuff_lead_four(group_stuff_lead_four),
    .group_over_limit(group_over_limit), .group_under_limit(group_under_limit),
    .group_frame_len(group_frame_len)
  );

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  // One write strobe, taken at the next edge
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  // One read strobe; an extra edge lets rdata settle either way
  task automatic rd(input logic [8:0] a);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(posedge clock);
    #1;
    rd_val = rdata;
  endtask

  // Decoded outputs lag the register by one more cycle
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  // Byte compare, four-state exact
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read a register and compare
  task automatic rchk(input string what, input logic [8:0] a, input logic [7:0] exp);
    rd(a);
    chk(what, exp, rd_val);
  endtask

  // Measure cycles between two consecutive ticks of a group, bounded wait
  task automatic tick_gap(input int g, output int n);
    int k;
    n = 0;
    for (k = 0; k < 6000 && group_integ_tick[g] !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    for (k = 0; k < 6000; k++) begin
      @(posedge clock);
      #1;
      n++;
      if (group_integ_tick[g] === 1'b1) begin
        break;
      end
    end
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 20000 cycles
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    #1;
    // Reset values of offset, link control, group control and integration registers
    for (int i = 0; i < 8; i++) begin
      rchk("offset_rst", ADDR_OFFSET_BASE + 9'(i), 8'(i));
      rchk("lctl_rst", ADDR_LINK_CTL_BASE + 9'(i), 8'h04);
    end
    for (int g = 0; g < 4; g++) begin
      rchk("gctl_rst", ADDR_GROUP_CTL_BASE + 9'(g), 8'h29);
      rchk("integ_rst", ADDR_INTEG_BASE + 9'(g), 8'h05);
      chk("gctl_out_rst", 8'h29, {group_stuff_lead_four[g], group_over_limit[g], group_under_limit[g]});
    end
    chk("uni_rst", 8'hFF, link_uni_mode);
    chk("coset_rst", 8'hFF, link_coset_add);
    chk("offset_uni", 8'h00, link_offset[3]);
    // Status is read-only and starts all ones; unmapped reads give zero
    wr(ADDR_MODE_STATUS, 8'h00);
    rchk("status_rst", ADDR_MODE_STATUS, 8'hFF);
    rchk("unmapped", 9'h100, 8'h00);
    // Upper nibble of the integration register is not stored
    wr(ADDR_INTEG_BASE + 9'h2, 8'hAC);
    rchk("integ_nibble", ADDR_INTEG_BASE + 9'h2, 8'h0C);
    // Links 0..3 join groups 0..3, each group with its own frame length
    for (int g = 0; g < 4; g++) begin
      wr(ADDR_FRAME_BASE + 9'(g), 8'(g << 5));
      wr(ADDR_OFFSET_BASE + 9'(g), 8'hFF);
      wr(ADDR_LINK_CTL_BASE + 9'(g), 8'h04 | 8'(g));
      wr(ADDR_LINK_CTL_BASE + 9'(g), 8'(g));
    end
    settle();
    for (int g = 0; g < 4; g++) begin
      chk("offset_mask", 8'((9'h020 << g) - 9'h1), link_offset[g]);
      chk("group_num", 8'(g), {6'h0, link_group[g]});
      chk("frame_len", 8'(g), {6'h0, group_frame_len[g]});
      rchk("offset_rb", ADDR_OFFSET_BASE + 9'(g), 8'hFF);
    end
    chk("uni_ima", 8'hF0, link_uni_mode);
    rchk("status_ima", ADDR_MODE_STATUS, 8'hF0);
    // Mode bits in IMA: user cells, coset and scrambling
    wr(ADDR_LINK_CTL_BASE, 8'h40);
    settle();
    chk("lctl_ima_a", 8'h06, {5'h0, link_send_user[0], link_coset_add[0], link_scramble[0]});
    wr(ADDR_LINK_CTL_BASE, 8'h30);
    settle();
    chk("lctl_ima_b", 8'h01, {5'h0, link_send_user[0], link_coset_add[0], link_scramble[0]});
    // UNI link ignores its user bit and follows the cell-bus enable
    wr(ADDR_LINK_CTL_BASE + 9'h7, 8'h04);
    @(posedge clock);
    phy_user_enable <= 8'h80;
    settle();
    chk("uni_user_on", 8'h01, {7'h0, link_send_user[7]});
    wr(ADDR_LINK_CTL_BASE + 9'h7, 8'h44);
    @(posedge clock);
    phy_user_enable <= 8'h00;
    settle();
    chk("uni_user_off", 8'h00, {7'h0, link_send_user[7]});
    // Leaving IMA: status holds until the datapath reports drained
    wr(ADDR_LINK_CTL_BASE, 8'h04);
    settle();
    rchk("status_hold", ADDR_MODE_STATUS, 8'hF0);
    @(posedge clock);
    link_drain_done <= 8'h01;
    settle();
    rchk("status_back", ADDR_MODE_STATUS, 8'hF1);
    // Group control fields per group
    for (int g = 0; g < 4; g++) begin
      wr(ADDR_GROUP_CTL_BASE + 9'(g), 8'(((g & 1) << 7) | ((g + 6) << 3) | (7 - g)));
    end
    settle();
    for (int g = 0; g < 4; g++) begin
      chk("gctl_out", 8'(((g & 1) << 7) | ((g + 6) << 3) | (7 - g)),
          {group_stuff_lead_four[g], group_over_limit[g], group_under_limit[g]});
    end
    // Integration period: codes 0 and 1 give 128 and 256 cycles
    wr(ADDR_INTEG_BASE, 8'h00);
    wr(ADDR_INTEG_BASE + 9'h1, 8'h01);
    tick_gap(0, gap);
    tick_gap(0, gap);
    chk("integ_code0", 8'h80, 8'(gap));
    tick_gap(1, gap);
    tick_gap(1, gap);
    chk("integ_code1", 8'h01, 8'(gap >> 8));
    chk("integ_code1_lo", 8'h00, 8'(gap));
    tally_and_finish();
  end
endmodule
`default_nettype wire
